// ===== design/device_status_field_encoder.sv
/*
 * device status field encoder: keeps the status and diagnostic fields and sends
 * the 18-byte status or 40-byte diagnostic record, high byte first, one byte per
 * enabled clock.
 * assumes: inputs on ref_clk_i except the two sync lock pins, synchronised here;
 * the stream sink always accepts.
 */
// What this block does
// - time fields: ten value bits, 0..999
// - currents: 24-bit sign-magnitude, one microamp steps
// - first generation: two currents lead status record
// - first generation: six 12-bit rail codes
// - later generation: reserved bytes, voltages, big-endian
// - diagnostic byte 11: checksum pass or fail
// - two 16-bit link error counters
// - temperatures one-four: 13-bit signed, bits 15..3
// - temperatures one-two bottom, three-four top
// - fifth temperature: 12-bit signed, bits 11..0
// - byte 16: pps, rmc, utc status bits
// - motor speed in bytes 32 and 33
`timescale 1ns/1ns
`default_nettype none

module device_status_field_encoder
(
    // clock, reset, enable
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         clk_en_i,
    // configuration
    input  wire logic         gen_later_i,          // 1: later hardware generation
    // record requests, one-cycle pulses
    input  wire logic         send_status_i,
    input  wire logic         send_diag_i,
    // time values
    input  wire logic [9:0]   time_millis_i,
    input  wire logic [9:0]   time_micros_i,
    // supply currents, two's complement microamps
    input  wire logic [23:0]  sensor_current_i,
    input  wire logic [23:0]  top_current_i,
    // rail codes, rail k at bits 12k+11..12k
    input  wire logic [71:0]  rail_codes_i,
    // compensation data checksum
    input  wire logic         comp_checksum_fail_i,
    // link error pulses
    input  wire logic         single_bit_err_i,
    input  wire logic         double_bit_err_i,
    // temperatures, two's complement
    input  wire logic [12:0]  temp_bottom_a_i,      // 1/16 degree steps
    input  wire logic [12:0]  temp_bottom_b_i,
    input  wire logic [12:0]  temp_top_a_i,
    input  wire logic [12:0]  temp_top_b_i,
    input  wire logic [11:0]  temp_board5_i,        // 1/4 degree steps
    // time sync inputs
    input  wire logic         pulse_input_valid_i,  // pin
    input  wire logic         rmc_sentence_valid_i, // pin
    input  wire logic         timestamp_tracking_utc_i,
    // motor speed, six counts per unit of speed
    input  wire logic [15:0]  motor_speed_i,
    // field registers
    output logic [15:0]       time_millis_o,
    output logic [15:0]       time_micros_o,
    output logic [15:0]       link_single_bit_errors_o,
    output logic [15:0]       link_double_bit_errors_o,
    output logic [7:0]        sync_input_status_o,
    // record byte stream
    output logic [7:0]        rec_byte_o,
    output logic              rec_valid_o,
    output logic              rec_first_o,
    output logic              rec_last_o,
    output logic              rec_is_diag_o,
    output logic              busy_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    status_field_pkg::send_state_t  state_q;        // sender state
    status_field_pkg::send_state_t  state_d;
    logic [319:0]  shift_q;                         // remaining bytes, next at the top
    logic [5:0]    remain_q;                        // bytes still to send after rec_byte_o
    logic          pps_sync;                        // synchronised pulse lock
    logic          rmc_sync;                        // synchronised rmc lock
    logic [15:0]   err_single;                      // counter outputs
    logic [15:0]   err_double;

    // ************************************************************
    // sync lock pins
    // ************************************************************
    // pins are asynchronous, so each goes through two flops first
    pin_sync u_pps_sync
    (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .async_i   (pulse_input_valid_i),
        .sync_o    (pps_sync)
    );

    pin_sync u_rmc_sync
    (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .async_i   (rmc_sentence_valid_i),
        .sync_o    (rmc_sync)
    );

    // ************************************************************
    // request decode
    // ************************************************************
    wire   idle        = (state_q == status_field_pkg::ST_IDLE);
    wire   take_status = clk_en_i && idle && send_status_i;          // status wins a tie
    wire   take_diag   = clk_en_i && idle && send_diag_i && !send_status_i;
    wire   take_any    = take_status || take_diag;
    wire   last_sent   = (remain_q == 6'h00);

    // ************************************************************
    // link error counters
    // ************************************************************
    // the window restarts whenever a diagnostic record snapshots the counts
    link_error_counter u_err_single
    (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .err_i     (single_bit_err_i),
        .clear_i   (take_diag),
        .count_o   (err_single)
    );

    link_error_counter u_err_double
    (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .err_i     (double_bit_err_i),
        .clear_i   (take_diag),
        .count_o   (err_double)
    );

    // ************************************************************
    // field encoding
    // ************************************************************
    wire [23:0] sensor_cur_f = status_field_pkg::to_sign_mag(sensor_current_i);
    wire [23:0] top_cur_f    = status_field_pkg::to_sign_mag(top_current_i);

    // rail codes in 16-bit fields with a zero top nibble
    wire [15:0] rail_f [6];
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_rail
            assign rail_f[gi] = status_field_pkg::field12(rail_codes_i[gi*12 +: 12]);
        end
    endgenerate

    // board temperatures; one-two bottom, three-four top
    wire [15:0] temp1_f = status_field_pkg::temp13_field(temp_bottom_a_i);
    wire [15:0] temp2_f = status_field_pkg::temp13_field(temp_bottom_b_i);
    wire [15:0] temp3_f = status_field_pkg::temp13_field(temp_top_a_i);
    wire [15:0] temp4_f = status_field_pkg::temp13_field(temp_top_b_i);
    wire [15:0] temp5_f = status_field_pkg::field12(temp_board5_i);

    // checksum byte is a full byte code, not a single bit
    wire [7:0]  cksum_f = comp_checksum_fail_i ? status_field_pkg::CKSUM_FAIL
                                               : status_field_pkg::CKSUM_PASS;

    // sync status byte, reserved bits zero
    logic [7:0] sync_f;
    always_comb
    begin
        sync_f = status_field_pkg::BYTE_RST;
        sync_f[status_field_pkg::SYNC_PPS_BIT] = pps_sync;
        sync_f[status_field_pkg::SYNC_RMC_BIT] = rmc_sync;
        sync_f[status_field_pkg::SYNC_UTC_BIT] = timestamp_tracking_utc_i;
    end

    // ************************************************************
    // record assembly, byte 1 in the top bits
    // ************************************************************
    // first generation: two currents, then six rails
    wire [143:0] status_gen1 = {sensor_cur_f, top_cur_f,
                                rail_f[0], rail_f[1], rail_f[2],
                                rail_f[3], rail_f[4], rail_f[5]};
    // later generation: eight zero bytes, then the rails that fit bytes 9..18
    wire [143:0] status_gen2 = {64'h0000_0000_0000_0000,
                                rail_f[0], rail_f[1], rail_f[2],
                                rail_f[3], rail_f[4]};
    wire [143:0] status_rec  = gen_later_i ? status_gen2 : status_gen1;

    // diagnostic record: debug bytes 1..10, 27..31 and 34..40 are zero
    wire [319:0] diag_rec = {80'h0,
                             cksum_f,
                             err_single, err_double,
                             sync_f,
                             temp1_f, temp2_f, temp3_f, temp4_f, temp5_f,
                             40'h0,
                             motor_speed_i,
                             56'h0};

    // the chosen record, left aligned so both kinds leave from the top byte
    wire [319:0] load_rec = take_status ? {status_rec, 176'h0} : diag_rec;
    wire [5:0]   load_len = take_status ? status_field_pkg::STATUS_LEN
                                        : status_field_pkg::DIAG_LEN;

    // ************************************************************
    // sender state machine
    // ************************************************************
    always_comb
    begin
        case (state_q)
            status_field_pkg::ST_IDLE:
                state_d = take_any ? status_field_pkg::ST_SEND : status_field_pkg::ST_IDLE;
            status_field_pkg::ST_SEND:
                state_d = last_sent ? status_field_pkg::ST_IDLE : status_field_pkg::ST_SEND;
            default:
                state_d = status_field_pkg::ST_IDLE;        // recover from an illegal code
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            state_q <= status_field_pkg::ST_IDLE;
        else if (clk_en_i)
            state_q <= state_d;
    end

    // ************************************************************
    // byte stream
    // ************************************************************
    // the whole record is captured at the request, so fields that change while
    // it is sent cannot tear a multi-byte value
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            shift_q       <= '0;
            remain_q      <= 6'h00;
            rec_byte_o    <= status_field_pkg::BYTE_RST;
            rec_valid_o   <= 1'b0;
            rec_first_o   <= 1'b0;
            rec_last_o    <= 1'b0;
            rec_is_diag_o <= 1'b0;
            busy_o        <= 1'b0;
        end
        else if (take_any)
        begin
            // first byte leaves on the next edge's output
            rec_byte_o    <= load_rec[319:312];
            shift_q       <= {load_rec[311:0], 8'h00};
            remain_q      <= load_len - 6'h01;
            rec_valid_o   <= 1'b1;
            rec_first_o   <= 1'b1;
            rec_last_o    <= 1'b0;
            rec_is_diag_o <= take_diag;
            busy_o        <= 1'b1;
        end
        else if (clk_en_i && !idle)
        begin
            if (last_sent)
            begin
                // record finished, stream goes quiet
                rec_byte_o  <= status_field_pkg::BYTE_RST;
                rec_valid_o <= 1'b0;
                rec_first_o <= 1'b0;
                rec_last_o  <= 1'b0;
                busy_o      <= 1'b0;
            end
            else
            begin
                // high-order bytes always go first
                rec_byte_o  <= shift_q[319:312];
                shift_q     <= {shift_q[311:0], 8'h00};
                remain_q    <= remain_q - 6'h01;
                rec_first_o <= 1'b0;
                rec_last_o  <= (remain_q == 6'h01);
            end
        end
    end

    // ************************************************************
    // field registers
    // ************************************************************
    // updated every enabled cycle; out-of-range time values are clamped to 999
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            time_millis_o       <= status_field_pkg::FIELD16_RST;
            time_micros_o       <= status_field_pkg::FIELD16_RST;
            sync_input_status_o <= status_field_pkg::BYTE_RST;
        end
        else if (clk_en_i)
        begin
            time_millis_o       <= status_field_pkg::time_field(time_millis_i);
            time_micros_o       <= status_field_pkg::time_field(time_micros_i);
            sync_input_status_o <= sync_f;
        end
    end

    // counts come straight from the counter flops
    assign link_single_bit_errors_o = err_single;
    assign link_double_bit_errors_o = err_double;

endmodule : device_status_field_encoder

`default_nettype wire

// ===== design/link_error_counter.sv
/*
 * 16-bit saturating link error counter.
 * assumes: err_i comes from the same clock; clear_i marks a snapshot cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module link_error_counter
(
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         clk_en_i,
    // events
    input  wire logic         err_i,
    input  wire logic         clear_i,
    // count
    output logic [15:0]       count_o
);

    wire   at_max = (count_o == status_field_pkg::ERR_CNT_MAX);   // stop before wrap

    // an error in the clearing cycle is kept as the first of the new window
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            count_o <= status_field_pkg::FIELD16_RST;
        else if (clk_en_i && clear_i)
            count_o <= {15'h0000, err_i};
        else if (clk_en_i && err_i && !at_max)
            count_o <= count_o + 16'h0001;
    end

endmodule : link_error_counter

`default_nettype wire

// ===== design/pin_sync.sv
/*
 * two-flop synchroniser for one pin level.
 * assumes: the level is slow against the clock.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_sync
(
    // clock and reset
    input  wire logic  ref_clk_i,
    input  wire logic  nrst_i,
    input  wire logic  clk_en_i,
    // level in and out
    input  wire logic  async_i,
    output logic       sync_o
);

    logic  meta_q;    // first stage, read only by the second stage

    // both stages freeze with the clock enable
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : pin_sync

`default_nettype wire

// ===== design/status_field_pkg.sv
/*
 * constants, state type and field helpers of the status field encoder.
 * assumes: one clock domain; users write status_field_pkg::name.
 */
package status_field_pkg;

    // ************************************************************
    // record geometry
    // ************************************************************
    localparam int unsigned  REC_MAX_BYTES  = 40;            // longest record (diagnostic)
    localparam int unsigned  REC_MAX_BITS   = REC_MAX_BYTES * 8;
    localparam logic [5:0]   STATUS_LEN     = 6'h12;         // status record, 18 bytes
    localparam logic [5:0]   DIAG_LEN       = 6'h28;         // diagnostic record, 40 bytes
    localparam int unsigned  STATUS_BITS    = 144;           // 18 bytes as bits
    localparam int unsigned  DIAG_BITS      = 320;           // 40 bytes as bits

    // ************************************************************
    // field widths and codes
    // ************************************************************
    localparam int unsigned  TIME_VAL_W     = 10;            // millis / micros value bits
    localparam logic [9:0]   TIME_MAX       = 10'h3E7;       // largest legal value, 999
    localparam int unsigned  RAIL_W         = 12;            // measured rail code bits
    localparam int unsigned  RAIL_COUNT     = 6;             // rail fields on first generation
    localparam int unsigned  ERR_CNT_W      = 16;            // link error counter width
    localparam logic [15:0]  ERR_CNT_MAX    = 16'hFFFF;      // counter saturates here
    localparam logic [7:0]   CKSUM_PASS     = 8'h00;         // compensation data checksum good
    localparam logic [7:0]   CKSUM_FAIL     = 8'h01;         // compensation data checksum bad
    localparam logic [22:0]  CUR_MAG_MAX    = 23'h7FFFFF;    // largest current magnitude

    // ************************************************************
    // sync input status byte layout
    // ************************************************************
    localparam int unsigned  SYNC_PPS_BIT   = 0;             // pulse-per-second input valid
    localparam int unsigned  SYNC_RMC_BIT   = 1;             // rmc sentence valid
    localparam int unsigned  SYNC_UTC_BIT   = 2;             // timestamp tracking utc

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0]  FIELD16_RST    = 16'h0000;
    localparam logic [7:0]   BYTE_RST       = 8'h00;

    // ************************************************************
    // sender state, one-hot
    // ************************************************************
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } send_state_t;

    // ************************************************************
    // helpers
    // ************************************************************
    // two's complement microamps to 24-bit sign-magnitude; the one value whose
    // magnitude does not fit (-2^23) saturates to the largest magnitude
    function automatic logic [23:0] to_sign_mag(input logic [23:0] val);
        logic [23:0] neg;
        neg = 24'h000000 - val;
        if (!val[23])
            to_sign_mag = {1'b0, val[22:0]};
        else if (neg[23])
            to_sign_mag = {1'b1, CUR_MAG_MAX};
        else
            to_sign_mag = {1'b1, neg[22:0]};
    endfunction : to_sign_mag

    // clamp a time value into 0..999 and pad with zero reserved bits
    function automatic logic [15:0] time_field(input logic [9:0] val);
        logic [9:0] lim;
        lim = (val > TIME_MAX) ? TIME_MAX : val;
        time_field = {6'h00, lim};
    endfunction : time_field

    // 12-bit measured code in a 16-bit field, unused top nibble zero
    function automatic logic [15:0] field12(input logic [11:0] val);
        field12 = {4'h0, val};
    endfunction : field12

    // 13-bit signed temperature in bits 15..3, ignored low bits zero
    function automatic logic [15:0] temp13_field(input logic [12:0] val);
        temp13_field = {val, 3'b000};
    endfunction : temp13_field

endpackage : status_field_pkg

// ===== sim/device_status_field_encoder_chk.sv
/* checker: field and record stream properties.
   assumes: bound to the encoder top, one clock. */
`timescale 1ns/1ns
`default_nettype none
module status_encoder_chk
(
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic        clk_en_i,
    // watched inputs
    input wire logic        gen_later_i,
    input wire logic        send_status_i,
    input wire logic        timestamp_tracking_utc_i,
    input wire logic [9:0]  time_millis_i,
    input wire logic [9:0]  time_micros_i,
    // watched outputs
    input wire logic [15:0] time_millis_o,
    input wire logic [15:0] time_micros_o,
    input wire logic [7:0]  sync_input_status_o,
    input wire logic [7:0]  rec_byte_o,
    input wire logic        rec_valid_o,
    input wire logic        rec_first_o,
    input wire logic        rec_last_o,
    input wire logic        rec_is_diag_o,
    input wire logic        busy_o
);
    logic [5:0] cnt_q;   // index of the byte shown, 0 = byte 1
    wire        diag_w = rec_is_diag_o && rec_valid_o;
    wire        stat_w = !rec_is_diag_o && rec_valid_o;
    // byte index; idle clears it
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i || !rec_valid_o) cnt_q <= 6'h00;
        else if (clk_en_i) cnt_q <= cnt_q + 6'h01;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_millis_value: assert property (clk_en_i && time_millis_i <= 10'h3E7
        |=> time_millis_o == {6'h00, $past(time_millis_i)}) else $error("millis field wrong");
    a_micros_clamp: assert property (clk_en_i && time_micros_i > 10'h3E7
        |=> time_micros_o == 16'h03E7) else $error("micros field not limited");
    a_utc_bit: assert property (clk_en_i |=> sync_input_status_o[7:3] == 5'h00 &&
        sync_input_status_o[2] == $past(timestamp_tracking_utc_i)) else $error("sync byte wrong");
    a_status_start: assert property (!busy_o && clk_en_i && send_status_i
        |=> rec_first_o && rec_valid_o && !rec_is_diag_o) else $error("status record not begun");
    a_record_len: assert property (rec_last_o
        |-> cnt_q == (rec_is_diag_o ? 6'h27 : 6'h11)) else $error("record length wrong");
    a_cksum_byte: assert property (diag_w && cnt_q == 6'h0A
        |-> rec_byte_o[7:1] == 7'h00) else $error("checksum byte has stray bits");
    a_temp_lowbits: assert property (diag_w && cnt_q inside {6'h11, 6'h13, 6'h15, 6'h17}
        |-> rec_byte_o[2:0] == 3'h0) else $error("temperature low bits not zero");
    a_temp5_nibble: assert property (diag_w && cnt_q == 6'h18
        |-> rec_byte_o[7:4] == 4'h0) else $error("fifth temperature top nibble set");
    a_rail_nibble: assert property (stat_w && cnt_q >= 6'h08 && !cnt_q[0]
        |-> rec_byte_o[7:4] == 4'h0) else $error("rail top nibble set");
    a_later_resv: assert property (stat_w && gen_later_i && cnt_q < 6'h08
        |-> rec_byte_o == 8'h00) else $error("reserved status byte not zero");
    c_status_old: cover property (rec_last_o && !rec_is_diag_o && !gen_later_i);
    c_status_new: cover property (rec_last_o && !rec_is_diag_o && gen_later_i);
    c_diag: cover property (rec_last_o && rec_is_diag_o);
endmodule : status_encoder_chk
bind device_status_field_encoder status_encoder_chk u_chk (.ref_clk_i, .nrst_i, .clk_en_i,
    .gen_later_i, .send_status_i, .timestamp_tracking_utc_i, .time_millis_i, .time_micros_i,
    .time_millis_o, .time_micros_o, .sync_input_status_o, .rec_byte_o, .rec_valid_o,
    .rec_first_o, .rec_last_o, .rec_is_diag_o, .busy_o);
`default_nettype wire

// ===== sim/device_status_field_encoder_tb_top.sv
/* testbench: sends records and compares every byte.
   assumes: host sink and bound checker compiled alongside. */
`timescale 1ns/1ns
`default_nettype none
module device_status_field_encoder_tb_top;
    logic ref_clk_i, nrst_i, clk_en_i, gen_later_i, send_status_i, send_diag_i;
    logic [9:0] time_millis_i, time_micros_i;
    logic [23:0] sensor_current_i, top_current_i;
    logic [71:0] rail_codes_i;
    logic comp_checksum_fail_i, single_bit_err_i, double_bit_err_i;
    logic [12:0] temp_bottom_a_i, temp_bottom_b_i, temp_top_a_i, temp_top_b_i;
    logic [11:0] temp_board5_i;
    logic pulse_input_valid_i, rmc_sentence_valid_i, timestamp_tracking_utc_i;
    logic [15:0] motor_speed_i, time_millis_o, time_micros_o;
    logic [15:0] link_single_bit_errors_o, link_double_bit_errors_o;
    logic [7:0] sync_input_status_o, rec_byte_o;
    logic rec_valid_o, rec_first_o, rec_last_o, rec_is_diag_o, busy_o;
    int miscompares = 0, n_compared = 0;
    device_status_field_encoder DUT (.ref_clk_i, .nrst_i, .clk_en_i, .gen_later_i,
        .send_status_i, .send_diag_i, .time_millis_i, .time_micros_i, .sensor_current_i,
        .top_current_i, .rail_codes_i, .comp_checksum_fail_i, .single_bit_err_i,
        .double_bit_err_i, .temp_bottom_a_i, .temp_bottom_b_i, .temp_top_a_i, .temp_top_b_i,
        .temp_board5_i, .pulse_input_valid_i, .rmc_sentence_valid_i, .timestamp_tracking_utc_i,
        .motor_speed_i, .time_millis_o, .time_micros_o, .link_single_bit_errors_o,
        .link_double_bit_errors_o, .sync_input_status_o, .rec_byte_o, .rec_valid_o,
        .rec_first_o, .rec_last_o, .rec_is_diag_o, .busy_o);
    host_record_sink HOST (.ref_clk_i, .rec_byte_i(rec_byte_o), .rec_valid_i(rec_valid_o),
        .rec_first_i(rec_first_o));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic give_verdict();
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask : check8
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: field %h, wanted %h", $time, got, exp);
        end
    endtask : check16
    // request pulse, diag line always up so status must win; bounded wait
    task automatic run_record(input logic diag);
        int k;
        @(negedge ref_clk_i);
        send_status_i = !diag;
        send_diag_i = 1'b1;
        @(negedge ref_clk_i);
        send_status_i = 1'b0;
        send_diag_i = 1'b0;
        for (k = 0; k < 60 && rec_last_o !== 1'b1; k++) @(negedge ref_clk_i);
        if (k == 60)
        begin
            miscompares++;
            give_verdict();
        end
        check8({busy_o, rec_valid_o, rec_is_diag_o}, {2'b11, diag});
        @(negedge ref_clk_i);
    endtask : run_record
    task automatic chk_rec(input logic [319:0] e, input int n);
        for (int i = 0; i < n; i++)
            check8(HOST.rx_q[i], e[8*(n-1-i) +: 8]);
    endtask : chk_rec
    // diagnostic image: debug zeros, checksum, counts, sync, temps, speed
    function automatic logic [319:0] diag_exp(input logic [7:0] c, input logic [31:0] e);
        diag_exp = {80'h0, c, e, 8'h07, 16'hFFF8, 16'h0008, 16'h8000, 16'h7FF8, 16'h0800,
                    40'h0, 16'h1770, 56'h0};
    endfunction : diag_exp
    initial
    begin
        {nrst_i, gen_later_i, send_status_i, send_diag_i, single_bit_err_i} = '0;
        {double_bit_err_i, clk_en_i, comp_checksum_fail_i} = 3'b011;
        {pulse_input_valid_i, rmc_sentence_valid_i, timestamp_tracking_utc_i} = 3'b111;
        time_millis_i = 10'h3E7;
        time_micros_i = 10'h3FF;
        sensor_current_i = 24'hF32B00;   // minus 0x0CD500 microamps
        top_current_i = 24'h001234;
        rail_codes_i = {12'h605, 12'h504, 12'h403, 12'h302, 12'h201, 12'hF00};
        {temp_bottom_a_i, temp_bottom_b_i} = {13'h1FFF, 13'h0001};
        {temp_top_a_i, temp_top_b_i} = {13'h1000, 13'h0FFF};
        temp_board5_i = 12'h800;
        motor_speed_i = 16'h1770;
        repeat (20) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        {single_bit_err_i, double_bit_err_i} = 2'b11;
        repeat (2) @(negedge ref_clk_i);
        {double_bit_err_i, clk_en_i} = 2'b00;
        repeat (2) @(negedge ref_clk_i);
        {single_bit_err_i, clk_en_i} = 2'b01;
        repeat (3) @(negedge ref_clk_i);
        check16(time_millis_o, 16'h03E7);
        check16(time_micros_o, 16'h03E7);
        check8(sync_input_status_o, 8'h07);
        check16(link_single_bit_errors_o, 16'h0002);
        check16(link_double_bit_errors_o, 16'h0002);
        run_record(1'b0);
        chk_rec({24'h8CD500, 24'h001234, 96'h0F00_0201_0302_0403_0504_0605}, 18);
        gen_later_i = 1'b1;
        run_record(1'b0);
        chk_rec({64'h0, 80'h0F00_0201_0302_0403_0504}, 18);
        run_record(1'b1);
        chk_rec(diag_exp(8'h01, 32'h0002_0002), 40);
        comp_checksum_fail_i = 1'b0;
        run_record(1'b1);
        chk_rec(diag_exp(8'h00, 32'h0), 40);
        give_verdict();
    end
endmodule : device_status_field_encoder_tb_top
`default_nettype wire

// ===== sim/host_record_sink.sv
/* host side: gathers each record into a byte array.
   assumes: clock enable high during records. */
`timescale 1ns/1ns
`default_nettype none
module host_record_sink
(
    // clock
    input wire logic       ref_clk_i,
    // record stream
    input wire logic [7:0] rec_byte_i,
    input wire logic       rec_valid_i,
    input wire logic       rec_first_i
);
    logic [7:0] rx_q [0:39];   // received bytes, byte 1 at index 0
    logic [5:0] idx_q;         // next free index
    // capture; the first flag restarts the index so a lost byte cannot shift records
    always_ff @(posedge ref_clk_i)
    begin
        if (rec_valid_i)
        begin
            rx_q[rec_first_i ? 6'h00 : idx_q] <= rec_byte_i;
            idx_q <= rec_first_i ? 6'h01 : idx_q + 6'h01;
        end
    end
endmodule : host_record_sink
`default_nettype wire
